//--- afe_ctrl_defs.svh
// Register offsets, field positions, reset values and fixed constants of the control bank
`ifndef AFE_CTRL_DEFS_SVH
`define AFE_CTRL_DEFS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define REG_MODE_CTRL      3'h0
`define REG_CLAMP_DIS      3'h1
`define REG_TEST_A         3'h2
`define REG_TEST_B         3'h3
`define REG_TEST_C         3'h4
`define REG_CLAMP_LVL_CTRL 3'h5
`define REG_CLAMP_TARGET   3'h6
`define REG_COUNT          7
`define REG_LAST_IDX       3'h6

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define BIT_PART_SELECT    0
`define FLD_MODE_MSB       2
`define FLD_MODE_LSB       1
`define BIT_EDGE_POL       4
`define BIT_FAST_CLAMP     5
`define BIT_DOUT_OFF       7
`define BIT_LOOP_OFF       6
`define BIT_PROG_TGT_EN    0
`define BIT_TGT_UPDATE     1

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define RST_MODE_CTRL      8'h03
`define RST_OTHER          8'h00

// -----------------------------------------------------------------------------
// Serial framing and clamp loop constants
// -----------------------------------------------------------------------------
`define BYTE_LAST_BIT      3'h7
`define FIXED_TARGET       10'h1EC
`define LOOP_SHIFT_NORMAL  4'h4
`define LOOP_SHIFT_FAST    4'h3

`endif

//--- afe_ctrl_pkg.sv
// Types shared by the imaging front-end control bank
package afe_ctrl_pkg;

  // Operating mode field encoding
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'h0,
    MODE_GAIN_6DB = 2'h1,
    MODE_TEST = 2'h2,
    MODE_GAIN_0DB = 2'h3
  } op_mode_t;

  // Serial receiver states, one-hot
  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  // Decoded control settings presented to the analog core
  typedef struct packed {
    op_mode_t mode;
    logic output_edge_polarity;
    logic fast_clamp_select;
    logic data_out_off;
    logic black_loop_off;
    logic programmable_target_enable;
  } ctrl_t;

endpackage

//--- afe_host_model.sv
// Host timing model: serial port writer, pixel clock and black window
`timescale 1ns/1ns
module afe_host_model (
  // Clock
  input wire logic i_mclk,
  // Pins toward the bank
  output logic o_sck,
  output logic o_strobe,
  output logic o_serial_data_in,
  output logic o_sample_clock,
  output logic o_window
);
  // Idle levels at time zero
  initial begin
    o_sck = 1'b0;
    o_strobe = 1'b1;
    o_serial_data_in = 1'b0;
    o_sample_clock = 1'b0;
    o_window = 1'b0;
  end
  // Pixel clock, 160 ns period
  always #80 o_sample_clock = ~o_sample_clock;
  // One burst from register 0 upward, four mclk per serial clock phase (160 ns period)
  task automatic burst(input logic [7:0] b [$]);
    @(negedge i_mclk);
    o_strobe = 1'b0;
    foreach (b[k]) begin
      for (int i = 0; i < 8; i++) begin
        o_serial_data_in = b[k][i];
        repeat (4) @(negedge i_mclk);
        o_sck = 1'b1;
        repeat (4) @(negedge i_mclk);
        o_sck = 1'b0;
      end
    end
    repeat (5) @(negedge i_mclk);
    o_strobe = 1'b1;
    o_serial_data_in = ~o_serial_data_in;
  endtask
  // Black window of 24 pixels, once per call
  task automatic pulse;
    @(posedge o_sample_clock);
    @(negedge i_mclk);
    o_window = 1'b1;
    repeat (24) @(posedge o_sample_clock);
    @(negedge i_mclk);
    o_window = 1'b0;
  endtask
endmodule

//--- imaging_afe_control_registers.sv
// Serial-loaded control register bank and digital black clamp of the imaging front end
//
// Overview of operation
// - Mode field: standby, 6dB, test, 0dB
// - Bit 4 picks output update clock edge
// - Bit 5 halves black loop time constant
// - Bit 7 tri-states all data outputs
// - Register 1 bit 6 turns clamp off
// - Target fixed 492 unless programmable enabled
// - Update gate passes new level to target
// - Target equals four times level register
// - Input sampled on rising sample clock edge
// - In black window, compare, filter, correct
// - Bytes shifted LSB first, one bit per rising edge
// - Burst starts at 0, latched on strobe
// - Writes accepted only with part select
`timescale 1ns/1ns
`include "afe_ctrl_defs.svh"
module imaging_afe_control_registers (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Serial control port pins
  input wire logic i_serial_clock,
  input wire logic i_serial_load_strobe,
  input wire logic i_serial_data_in,
  // Conversion timing pins
  input wire logic i_sample_clock,
  input wire logic i_black_window_pulse,
  // Converter code from the analog core
  input wire logic [13:0] i_adc_code,
  // Control settings to the analog core
  output afe_ctrl_pkg::ctrl_t o_ctrl,
  output logic [9:0] o_black_target,
  output logic signed [17:0] o_clamp_offset,
  // Data output pins
  output logic [13:0] o_data,
  output logic o_data_oe
);
  import afe_ctrl_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [4:0] pin_level;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;

  pin_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_pin({i_black_window_pulse, i_sample_clock, i_serial_data_in,
            !i_serial_load_strobe, i_serial_clock}),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  logic sck_rise;
  logic sl_level;
  logic sl_rise;
  logic sl_fall;
  logic serial_data_in_level;
  logic smp_rise;
  logic smp_fall;
  logic window_level;

  assign sck_rise = pin_rise[0];
  // Strobe is synchronised inverted: its idle-high level then matches the
  // cleared reset level, so no false strobe edge follows reset
  assign sl_level = !pin_level[1];
  assign sl_rise = pin_fall[1];
  assign sl_fall = pin_rise[1];
  assign serial_data_in_level = pin_level[2];
  assign smp_rise = pin_rise[3];
  assign smp_fall = pin_fall[3];
  assign window_level = pin_level[4];

  // ---------------------------------------------------------------------------
  // Serial receiver
  // ---------------------------------------------------------------------------
  ser_state_t ser_state_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] stage_q [`REG_COUNT];

  // Next shift value: new bit enters at the top so the first bit ends at bit 0
  assign shift_d = {serial_data_in_level, shift_q[7:1]};

  // Framing: low strobe opens a burst, rising strobe closes it
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ser_state_q <= SER_IDLE;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end else begin
      case (ser_state_q)
        SER_IDLE: begin
          if (sl_fall) begin
            ser_state_q <= SER_SHIFT;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 4'h0;
          end
        end
        SER_SHIFT: begin
          if (sl_rise) begin
            ser_state_q <= SER_IDLE;
          end else if (sck_rise && !sl_level) begin
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == `BYTE_LAST_BIT && byte_cnt_q < 4'(`REG_COUNT)) begin
              byte_cnt_q <= byte_cnt_q + 4'h1;
            end
          end
        end
        default: begin
          ser_state_q <= SER_IDLE;
        end
      endcase
    end
  end

  // Completed bytes are staged by position in the burst
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        stage_q[i] <= `RST_OTHER;
      end
    end else if (ser_state_q == SER_SHIFT && !sl_rise && sck_rise && !sl_level &&
                 bit_cnt_q == `BYTE_LAST_BIT && byte_cnt_q < 4'(`REG_COUNT)) begin
      stage_q[byte_cnt_q[2:0]] <= shift_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------------------
  logic [7:0] regs_q [`REG_COUNT];
  logic commit;

  // Commit only whole bytes of a burst whose first byte carries part select
  assign commit = (ser_state_q == SER_SHIFT) && sl_rise && (byte_cnt_q != 4'h0) &&
                  stage_q[`REG_MODE_CTRL][`BIT_PART_SELECT];

  // Bytes land at consecutive addresses from offset zero; partial byte dropped
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs_q[i] <= (i == 0) ? `RST_MODE_CTRL : `RST_OTHER;
      end
    end else if (commit) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        if (4'(i) < byte_cnt_q) begin
          regs_q[i] <= stage_q[i];
        end
      end
    end
  end

  // Decoded settings straight from register bits
  assign o_ctrl.mode = op_mode_t'(regs_q[`REG_MODE_CTRL][`FLD_MODE_MSB:`FLD_MODE_LSB]);
  assign o_ctrl.output_edge_polarity = regs_q[`REG_MODE_CTRL][`BIT_EDGE_POL];
  assign o_ctrl.fast_clamp_select = regs_q[`REG_MODE_CTRL][`BIT_FAST_CLAMP];
  assign o_ctrl.data_out_off = regs_q[`REG_MODE_CTRL][`BIT_DOUT_OFF];
  assign o_ctrl.black_loop_off = regs_q[`REG_CLAMP_DIS][`BIT_LOOP_OFF];
  assign o_ctrl.programmable_target_enable =
      regs_q[`REG_CLAMP_LVL_CTRL][`BIT_PROG_TGT_EN];

  // ---------------------------------------------------------------------------
  // Black target selection
  // ---------------------------------------------------------------------------
  logic [7:0] level_held_q;
  logic [9:0] target_q;

  // Level follows its register only while the update gate is open
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      level_held_q <= `RST_OTHER;
    end else if (regs_q[`REG_CLAMP_LVL_CTRL][`BIT_TGT_UPDATE]) begin
      level_held_q <= regs_q[`REG_CLAMP_TARGET];
    end
  end

  // Fixed target or four times the held level
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      target_q <= `FIXED_TARGET;
    end else if (regs_q[`REG_CLAMP_LVL_CTRL][`BIT_PROG_TGT_EN]) begin
      target_q <= {level_held_q, 2'b00};
    end else begin
      target_q <= `FIXED_TARGET;
    end
  end

  assign o_black_target = target_q;

  // ---------------------------------------------------------------------------
  // Sampling and clamp loop
  // ---------------------------------------------------------------------------
  logic [13:0] sample_q;
  logic sample_new_q;
  logic signed [17:0] acc_q;
  logic signed [17:0] err_ext;
  logic [3:0] loop_shift;
  logic running;

  // Standby halts all conversion work; registers are untouched
  assign running = (o_ctrl.mode != MODE_STANDBY);
  assign loop_shift = o_ctrl.fast_clamp_select ? `LOOP_SHIFT_FAST : `LOOP_SHIFT_NORMAL;
  assign err_ext = $signed({8'h00, target_q}) - $signed({4'h0, sample_q});

  // Capture converter code on rising sample clock
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      sample_q <= 14'h0000;
      sample_new_q <= 1'b0;
    end else begin
      sample_new_q <= 1'b0;
      if (smp_rise && running) begin
        sample_q <= i_adc_code;
        sample_new_q <= 1'b1;
      end
    end
  end

  // Integrate scaled error during the black window; shift sets time constant
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acc_q <= 18'sh00000;
    end else if (o_ctrl.black_loop_off) begin
      acc_q <= 18'sh00000;
    end else if (sample_new_q && window_level && running) begin
      acc_q <= acc_q + (err_ext >>> loop_shift);
    end
  end

  assign o_clamp_offset = acc_q;

  // ---------------------------------------------------------------------------
  // Data outputs
  // ---------------------------------------------------------------------------
  logic [13:0] data_q;
  logic oe_q;
  logic update_edge;

  // Selected sample clock edge moves the outputs
  assign update_edge = o_ctrl.output_edge_polarity ? smp_fall : smp_rise;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= 14'h0000;
    end else if (update_edge && running) begin
      data_q <= (o_ctrl.mode == MODE_TEST) ? {4'h0, target_q} : sample_q;
    end
  end

  // Output enable drops while the disable bit is set
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      oe_q <= 1'b1;
    end else begin
      oe_q <= !regs_q[`REG_MODE_CTRL][`BIT_DOUT_OFF];
    end
  end

  assign o_data = data_q;
  assign o_data_oe = oe_q;

endmodule

//--- imaging_afe_control_registers_asserts.sv
// Port-level checker for the serial control bank
`timescale 1ns/1ns
`include "afe_ctrl_defs.svh"
module imaging_afe_control_registers_asserts (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Pins
  input wire logic i_serial_load_strobe,
  input wire logic i_black_window_pulse,
  // Outputs of the bank
  input wire afe_ctrl_pkg::ctrl_t o_ctrl,
  input wire logic [9:0] o_black_target,
  input wire logic signed [17:0] o_clamp_offset,
  input wire logic [13:0] o_data,
  input wire logic o_data_oe
);
  import afe_ctrl_pkg::*;
  logic [4:0] test_cnt_q;
  logic [3:0] win_age_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Cycles spent in test mode with a steady target
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      test_cnt_q <= 5'h00;
    end else if (o_ctrl.mode != MODE_TEST || !$stable(o_black_target)) begin
      test_cnt_q <= 5'h00;
    end else if (test_cnt_q != 5'h1F) begin
      test_cnt_q <= test_cnt_q + 5'h01;
    end
  end
  // Cycles since the window pin was last high, saturating
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      win_age_q <= 4'h0;
    end else if (i_black_window_pulse) begin
      win_age_q <= 4'h0;
    end else if (win_age_q != 4'hF) begin
      win_age_q <= win_age_q + 4'h1;
    end
  end
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_oe_follows;
    (o_ctrl.mode != MODE_STANDBY && $stable(o_ctrl.data_out_off))[*3]
      |-> o_data_oe == !o_ctrl.data_out_off;
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("data enable wrong");
  property p_fixed_target;
    (!o_ctrl.programmable_target_enable)[*3] |-> o_black_target == `FIXED_TARGET;
  endproperty
  a_fixed_target: assert property (p_fixed_target) else $error("fixed target wrong");
  property p_target_step;
    o_ctrl.programmable_target_enable |-> o_black_target[1:0] == 2'h0;
  endproperty
  a_target_step: assert property (p_target_step) else $error("target not 4x");
  property p_loop_off;
    o_ctrl.black_loop_off[*2] |-> o_clamp_offset == 18'sh0;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("offset kept while off");
  property p_standby;
    (o_ctrl.mode == MODE_STANDBY)[*4] |-> $stable(o_data) && $stable(o_clamp_offset);
  endproperty
  a_standby: assert property (p_standby) else $error("activity in standby");
  property p_ctrl_on_strobe;
    !$stable(o_ctrl) |-> $past(i_serial_load_strobe, 3);
  endproperty
  a_ctrl_on_strobe: assert property (p_ctrl_on_strobe) else $error("early latch");
  property p_test_data;
    test_cnt_q == 5'h1F |-> o_data == {4'h0, o_black_target};
  endproperty
  a_test_data: assert property (p_test_data) else $error("test data wrong");
  property p_window;
    !$stable(o_clamp_offset) && !o_ctrl.black_loop_off |-> win_age_q < 4'hC;
  endproperty
  a_window: assert property (p_window) else $error("offset moved off window");
  // Main scenarios reached
  c_test: cover property (test_cnt_q == 5'h1F);
  c_window: cover property (!$stable(o_clamp_offset));
  c_tristate: cover property (!o_data_oe);
endmodule

bind imaging_afe_control_registers imaging_afe_control_registers_asserts u_chk (
  .i_mclk(i_mclk),
  .i_rst(i_rst),
  .i_serial_load_strobe(i_serial_load_strobe),
  .i_black_window_pulse(i_black_window_pulse),
  .o_ctrl(o_ctrl),
  .o_black_target(o_black_target),
  .o_clamp_offset(o_clamp_offset),
  .o_data(o_data),
  .o_data_oe(o_data_oe)
);

//--- imaging_afe_control_registers_test.sv
// Self-checking bench for the serial control bank
`timescale 1ns/1ns
module imaging_afe_control_registers_test;
  import afe_ctrl_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [13:0] adc = 14'h0000;
  logic sck, sl, sd, smp, win, oe;
  ctrl_t ctrl;
  logic [9:0] tgt;
  logic signed [17:0] ofs, o;
  logic [13:0] dat, d;
  logic [7:0] mdl [7];
  logic [7:0] sv;
  logic [31:0] v;
  logic [13:0] hist [$];
  int fails = 0, num_checks = 0, seed = 75, exp_tgt = 492, held = 0;
  always #10 i_mclk = ~i_mclk;
  always @(negedge i_mclk) adc <= 14'($random(seed));
  // Recent converter codes, newest first, as seen at each rising clock
  always @(posedge i_mclk) begin
    hist.push_front(adc);
    if (hist.size() > 32) begin
      void'(hist.pop_back());
    end
  end
  afe_host_model u_host (.i_mclk(i_mclk), .o_sck(sck), .o_strobe(sl), .o_serial_data_in(sd),
    .o_sample_clock(smp), .o_window(win));
  imaging_afe_control_registers u_dut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_serial_clock(sck), .i_serial_load_strobe(sl), .i_serial_data_in(sd),
    .i_sample_clock(smp), .i_black_window_pulse(win), .i_adc_code(adc), .o_ctrl(ctrl),
    .o_black_target(tgt), .o_clamp_offset(ofs), .o_data(dat), .o_data_oe(oe));
  // Compare and count
  task chk(input string n, input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Verdict and end of run
  task test_done;
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Write n bytes of the model registers, then update the expected target
  task automatic wr(input int n);
    logic [7:0] q [$];
    for (int k = 0; k < n; k++) q.push_back(mdl[k]);
    u_host.burst(q);
    if (mdl[0][0]) begin
      if (mdl[5][1]) held = 4 * mdl[6];
      exp_tgt = mdl[5][0] ? held : 492;
    end
    repeat (15) @(negedge i_mclk);
  endtask
  // Shown data must be a converter code taken within the last 32 cycles
  task automatic ck_data;
    logic hit;
    hit = 1'b0;
    repeat (20) @(negedge i_mclk);
    foreach (hist[k]) begin
      if (hist[k] === dat) hit = 1'b1;
    end
    chk("data_sample", 18'h1, 18'(hit));
  endtask
  // Compare all decoded settings with the model
  task ck_all;
    ctrl_t e;
    e.mode = op_mode_t'(mdl[0][2:1]);
    e.output_edge_polarity = mdl[0][4];
    e.fast_clamp_select = mdl[0][5];
    e.data_out_off = mdl[0][7];
    e.black_loop_off = mdl[1][6];
    e.programmable_target_enable = mdl[5][0];
    chk("ctrl", 18'(e), 18'(ctrl));
    chk("target", 18'(exp_tgt), 18'(tgt));
    chk("oe", 18'(!mdl[0][7]), 18'(oe));
  endtask
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    mdl = '{8'h03, 8'h00, 8'h48, 8'h63, 8'h10, 8'h00, 8'h00};
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_mclk);
    ck_all;
    for (int m = 0; m < 4; m++) begin
      v = $random(seed);
      mdl[0] = {m[0], 1'b0, v[5], m[1], 1'b0, m[1:0], 1'b1};
      mdl[1] = {1'b0, v[6], 6'h00};
      wr(7);
      ck_all;
      if (m[0]) begin
        ck_data;
      end
    end
    sv = mdl[0];
    mdl[0] = 8'h02;
    wr(1);
    mdl[0] = sv;
    ck_all;
    mdl[0] = 8'h03;
    mdl[1] = 8'h00;
    mdl[5] = 8'h03;
    mdl[6] = 8'hFF;
    wr(7);
    ck_all;
    mdl[5] = 8'h01;
    mdl[6] = v[7:0];
    wr(7);
    ck_all;
    u_host.pulse;
    repeat (12) @(negedge i_mclk);
    chk("offset_moved", 18'h1, 18'(ofs != 18'sh0));
    mdl[0] = 8'h05;
    wr(1);
    repeat (40) @(negedge i_mclk);
    chk("test_data", 18'(exp_tgt), 18'(dat));
    mdl[0] = 8'h01;
    wr(1);
    d = dat;
    o = ofs;
    u_host.pulse;
    chk("standby_data", 18'(d), 18'(dat));
    chk("standby_offset", 18'(o), 18'(ofs));
    mdl[0] = 8'h23;
    mdl[1] = 8'h40;
    mdl[5] = 8'h00;
    wr(6);
    ck_all;
    chk("offset_off", 18'h0, 18'(ofs));
    test_done;
  end
  // Hang guard
  initial begin
    #1000000;
    fails++;
    test_done;
  end
endmodule

//--- pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Raw pins
  input wire logic [WIDTH-1:0] i_pin,
  // Filtered level and edges
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] rise_q;
  logic [WIDTH-1:0] fall_q;

  // Synchroniser chain; only s2 reads s1
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only when second and third stages agree
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      level_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        rise_q[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level_q[i];
        fall_q[i] <= (s2_q[i] == s3_q[i]) && !s3_q[i] && level_q[i];
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign o_level = level_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;

endmodule
